/* File: src/bwa_adapter.sv */
`timescale 1ns/1ps
// ==========================================================
// Functional notes
// - Native slave: exactly one slave transfer per master transfer.
// - Native narrow read: slave data in low bits, upper bits zero.
// - Native: slave location n sits at master word n of address space.
// - Native narrow write: only low slave-width bits pass, rest dropped.
// - Dynamic slave: wide read runs enough narrow reads to fill word.
// - Dynamic read: every lane filled from successive slave locations.
// - Narrow master on wide slave: fetch whole word, hand selected part.
// - Part select multiplexer lives in this fabric block.
// - Each slave port has one fixed alignment setting; master has none.
// - Master always gets data of its own port width.
// - Slave not narrower than master: setting ignored, one transfer with lane select.
module bwa_adapter
    import bwa_pkg::*;
#(
    parameter int   MW    = BWA_MW_DEF,
    parameter int   SW    = BWA_SW_DEF,
    parameter logic ALIGN = BWA_ALIGN_DYNAMIC
) (
    // Clock and reset
    input  wire logic            clk,
    input  wire logic            nrst,
    // Master side
    input  wire logic            mValid,
    input  wire bwa_cmd_t        mCmd,
    input  wire logic [MW-1:0]   mWdata,
    output logic                 mReady,
    output logic                 mDone,
    output logic [MW-1:0]        mRdata,
    // Slave side
    output logic                 sValid,
    output logic                 sWrite,
    output logic [BWA_AW-1:0]    sAddr,
    output logic [SW-1:0]        sWdata,
    output logic [((SW >= 8) ? SW / 8 : 1)-1:0] sByteEn,
    input  wire logic            sAck,
    input  wire logic [SW-1:0]   sRdata
);

    // ======================================================
    // Derived geometry
    localparam int  SBE    = (SW >= 8) ? SW / 8 : 1;
    localparam int  MBYTES = (MW >= 8) ? MW / 8 : 1;
    localparam bit  NARROW = (SW < MW);
    localparam bit  DYN    = NARROW && (ALIGN == BWA_ALIGN_DYNAMIC);
    localparam int  NB     = DYN ? MW / SW : 1;
    localparam int  BW     = $clog2(NB) + 1;
    localparam int  MSH    = $clog2(MBYTES);
    localparam int  SSH    = $clog2(SBE);
    localparam int  LANES  = NARROW ? 1 : SW / MW;
    localparam int  LW     = (LANES > 1) ? $clog2(LANES) : 1;
    localparam logic [BW-1:0] LASTBEAT = BW'(NB - 1);

    // Slave location for a master address and beat
    function automatic logic [BWA_AW-1:0] slaveIndex(
        input logic [BWA_AW-1:0] addr,
        input logic [BW-1:0]     beat
    );
        if (!NARROW) begin
            slaveIndex = addr >> SSH;
        end else if (DYN) begin
            slaveIndex = (addr >> SSH) + BWA_AW'(beat);
        end else begin
            slaveIndex = addr >> MSH;
        end
    endfunction

    // Lane of a wide slave word picked by the master address
    function automatic logic [LW-1:0] laneOf(input logic [BWA_AW-1:0] addr);
        laneOf = LW'(addr >> MSH);
    endfunction

    // ======================================================
    // Reset release through two flip-flops
    logic rstMeta_r;
    logic rstSyncN_r;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rstMeta_r  <= 1'b0;
            rstSyncN_r <= 1'b0;
        end else begin
            rstMeta_r  <= 1'b1;
            rstSyncN_r <= rstMeta_r;
        end
    end

    // ======================================================
    // Sequencer state
    bwa_state_t         state_r,  state_nxt;
    bwa_cmd_t           cmd_r,    cmd_nxt;
    logic [MW-1:0]      wdata_r,  wdata_nxt;
    logic [MW-1:0]      rdata_r,  rdata_nxt;
    logic [BW-1:0]      beat_r,   beat_nxt;
    logic [MW-1:0]      laneData;

    // Half-word or lane multiplexer inside the fabric
    bwa_lane_sel #(
        .SW (SW),
        .MW (MW),
        .LW (LW)
    ) uLaneSel (
        .word     (sRdata),
        .lane     (laneOf(cmd_r.addr)),
        .laneData (laneData)
    );

    // Next state, beat count and gathered read word
    always_comb begin
        state_nxt = state_r;
        cmd_nxt   = cmd_r;
        wdata_nxt = wdata_r;
        rdata_nxt = rdata_r;
        beat_nxt  = beat_r;
        case (state_r)
            BWA_IDLE: begin
                if (mValid) begin
                    cmd_nxt   = mCmd;
                    wdata_nxt = mWdata;
                    beat_nxt  = '0;
                    rdata_nxt = '0;
                    state_nxt = BWA_BUSY;
                end
            end
            BWA_BUSY: begin
                if (sAck) begin
                    if (!cmd_r.write) begin
                        if (!NARROW) begin
                            rdata_nxt = laneData;
                        end else begin
                            // Each beat lands above the previous ones
                            rdata_nxt = rdata_r
                                | (MW'(sRdata) << (32'(beat_r) * SW));
                        end
                    end
                    if (beat_r == LASTBEAT) begin
                        state_nxt = BWA_DONE;
                    end else begin
                        beat_nxt = beat_r + BW'(1);
                    end
                end
            end
            BWA_DONE: begin
                state_nxt = BWA_IDLE;
            end
            default: begin
                state_nxt = BWA_IDLE;
            end
        endcase
    end

    // Sequencer registers
    always_ff @(posedge clk or negedge rstSyncN_r) begin
        if (!rstSyncN_r) begin
            state_r <= BWA_IDLE;
            cmd_r   <= '0;
            wdata_r <= '0;
            rdata_r <= MW'(BWA_RDATA_RST);
            beat_r  <= '0;
        end else begin
            state_r <= state_nxt;
            cmd_r   <= cmd_nxt;
            wdata_r <= wdata_nxt;
            rdata_r <= rdata_nxt;
            beat_r  <= beat_nxt;
        end
    end

    // ======================================================
    // Slave-side drive and master handshake
    always_comb begin
        mReady = (state_r == BWA_IDLE);
        mDone  = (state_r == BWA_DONE);
        mRdata = rdata_r;
        sValid = (state_r == BWA_BUSY);
        sWrite = (state_r == BWA_BUSY) && cmd_r.write;
        sAddr  = slaveIndex(cmd_r.addr, beat_r);
        sWdata = '0;
        sByteEn = '1;
        if (!NARROW) begin
            // Master data copied to every lane, enables pick one
            for (int i = 0; i < SW; i++) begin
                sWdata[i] = wdata_r[i % MW];
            end
            for (int j = 0; j < SBE; j++) begin
                sByteEn[j] = ((j / MBYTES) == 32'(laneOf(cmd_r.addr)));
            end
        end else begin
            sWdata = SW'(wdata_r >> (32'(beat_r) * SW));
        end
    end

    // ======================================================
    // Checks
    logic [BW:0] ackCnt_r;

    // Slave acknowledges counted over one master transfer
    always_ff @(posedge clk or negedge rstSyncN_r) begin
        if (!rstSyncN_r) begin
            ackCnt_r <= '0;
        end else if (state_r == BWA_IDLE) begin
            ackCnt_r <= '0;
        end else if (sValid && sAck) begin
            ackCnt_r <= ackCnt_r + (BW + 1)'(1);
        end
    end

    property p_beats;
        @(posedge clk) disable iff (!rstSyncN_r)
        mDone |-> ackCnt_r == (BW + 1)'(NB);
    endproperty
    a_beats: assert property (p_beats) else $error("wrong slave transfer count");

    property p_nativeAddr;
        @(posedge clk) disable iff (!rstSyncN_r)
        (sValid && NARROW && !DYN) |-> sAddr == (cmd_r.addr >> MSH);
    endproperty
    a_nativeAddr: assert property (p_nativeAddr) else $error("native index wrong");

    property p_nativeWrite;
        @(posedge clk) disable iff (!rstSyncN_r)
        (sWrite && NARROW) |-> sWdata == SW'(wdata_r >> (32'(beat_r) * SW));
    endproperty
    a_nativeWrite: assert property (p_nativeWrite) else $error("write slice wrong");

    property p_dynStep;
        @(posedge clk) disable iff (!rstSyncN_r)
        (sValid && sAck && DYN && beat_r != LASTBEAT)
            |=> sValid && sAddr == $past(sAddr) + BWA_AW'(1);
    endproperty
    a_dynStep: assert property (p_dynStep) else $error("dynamic address not stepping");

    property p_nativeRead;
        @(posedge clk) disable iff (!rstSyncN_r)
        (sValid && sAck && !cmd_r.write && NARROW && !DYN)
            |=> mDone && mRdata == MW'(($past(sRdata)));
    endproperty
    a_nativeRead: assert property (p_nativeRead) else $error("native read not in low bits");

    property p_wideRead;
        @(posedge clk) disable iff (!rstSyncN_r)
        (sValid && sAck && !cmd_r.write && !NARROW)
            |=> mDone && mRdata == $past(laneData);
    endproperty
    a_wideRead: assert property (p_wideRead) else $error("lane not delivered");

    property p_oneEnableLane;
        @(posedge clk) disable iff (!rstSyncN_r)
        (sWrite && !NARROW) |-> $countones(sByteEn) == MBYTES;
    endproperty
    a_oneEnableLane: assert property (p_oneEnableLane) else $error("lane enables wrong");

    property p_doneOnce;
        @(posedge clk) disable iff (!rstSyncN_r)
        mDone |=> mReady && !mDone;
    endproperty
    a_doneOnce: assert property (p_doneOnce) else $error("done not single");

    property p_takeStart;
        @(posedge clk) disable iff (!rstSyncN_r)
        (mValid && mReady) |=> sValid && sAddr == slaveIndex($past(mCmd.addr), BW'(0));
    endproperty
    a_takeStart: assert property (p_takeStart) else $error("request not started");

    c_dynRead:  cover property (@(posedge clk) disable iff (!rstSyncN_r)
        mDone && !cmd_r.write && DYN);
    c_write:    cover property (@(posedge clk) disable iff (!rstSyncN_r)
        mDone && cmd_r.write);
    c_backBack: cover property (@(posedge clk) disable iff (!rstSyncN_r)
        mDone ##1 (mValid && mReady));

endmodule

/* File: src/bwa_pkg.sv */
// ==========================================================
// Width adapter constants and carrier types
package bwa_pkg;

    // Default port widths
    localparam int BWA_MW_DEF = 32;
    localparam int BWA_SW_DEF = 8;
    localparam int BWA_AW     = 32;

    // Alignment setting encodings
    localparam logic BWA_ALIGN_NATIVE  = 1'h0;
    localparam logic BWA_ALIGN_DYNAMIC = 1'h1;

    // Reset value of the captured read word
    localparam logic [BWA_MW_DEF-1:0] BWA_RDATA_RST = 32'h0000_0000;

    // Master command carrier
    typedef struct packed {
        logic              write;
        logic [BWA_AW-1:0] addr;
    } bwa_cmd_t;

    // Adapter sequencing states
    typedef enum logic [1:0] {
        BWA_IDLE,
        BWA_BUSY,
        BWA_DONE
    } bwa_state_t;

endpackage

/* File: src/bwa_lane_sel.sv */
`timescale 1ns/1ps
// ==========================================================
// Selects one master-width lane out of a wide slave word
module bwa_lane_sel
    import bwa_pkg::*;
#(
    parameter int SW = 32,
    parameter int MW = 16,
    parameter int LW = 1
) (
    // Wide slave word and lane index
    input  wire logic [SW-1:0] word,
    input  wire logic [LW-1:0] lane,
    // Selected lane
    output logic      [MW-1:0] laneData
);

    // Shift the chosen lane down and keep master width
    always_comb begin
        laneData = MW'(word >> (32'(lane) * MW));
    end

endmodule

/* File: verif/bwa_slave_model.sv */
`timescale 1ns/1ps
// ==========================================================
// Slave peripheral model with random wait states
module bwa_slave_model
#(
    parameter int SW   = 8,
    parameter int SEED = 0
) (
    // Clock and reset
    input  wire logic          clk,
    input  wire logic          nrst,
    // Slave request
    input  wire logic          sValid,
    input  wire logic          sWrite,
    input  wire logic [31:0]   sAddr,
    input  wire logic [SW-1:0] sWdata,
    input  wire logic [((SW >= 8) ? SW / 8 : 1)-1:0] sByteEn,
    // Answer
    output logic               sAck,
    output logic [SW-1:0]      sRdata,
    output int                 nBeats
);
    logic [SW-1:0] mem [64];
    int            waitLeft_r;

    // One beat per request, answered after zero to two waits
    always @(posedge clk) begin
        if (!nrst) begin
            // Known contents, mirrored by the bench
            for (int i = 0; i < 64; i++) begin
                mem[i] <= SW'(i * 32'h9E37_79B1 + SEED);
            end
            sAck       <= 1'h0;
            sRdata     <= '0;
            nBeats     <= 0;
            waitLeft_r <= 0;
        end else if (sValid && !sAck && waitLeft_r == 0) begin
            sAck       <= 1'h1;
            nBeats     <= nBeats + 1;
            waitLeft_r <= $urandom_range(2, 0);
            if (sWrite) begin
                sRdata <= ~sRdata;
                // Only enabled byte lanes are written
                for (int b = 0; b < ((SW >= 8) ? SW / 8 : 1); b++) begin
                    if (sByteEn[b]) begin
                        mem[sAddr[5:0]][8*b +: 8] <= sWdata[8*b +: 8];
                    end
                end
            end else begin
                sRdata <= mem[sAddr[5:0]];
            end
        end else begin
            sAck   <= 1'h0;
            sRdata <= ~sRdata;  // No stale data off a beat
            if (sValid && !sAck) begin
                waitLeft_r <= waitLeft_r - 1;
            end
        end
    end
endmodule

/* File: verif/bwa_adapter_test.sv */
`timescale 1ns/1ps
// ==========================================================
// Bench: port 0 dynamic 32 from 8, port 1 native 32 from 8, port 2 16 from 32
module bwa_adapter_test
    import bwa_pkg::*;
;
    logic        clk = 1'h0;
    logic        nrst = 1'h0;
    logic        mValid [3];
    bwa_cmd_t    mCmd   [3];
    logic [31:0] mWd    [3];
    wire  [31:0] mRd    [3];
    wire         mReady [3];
    wire         mDone  [3];
    wire         sValid [3];
    wire         sWrite [3];
    wire  [31:0] sAddr  [3];
    wire  [31:0] sWd    [3];
    wire  [3:0]  sBe    [3];
    wire  [31:0] sRd    [3];
    wire         sAck   [3];
    wire  [31:0] nBeats [3];
    logic [31:0] sh     [3][64];
    int          fail_count = 0;
    int          n_checks = 0;

    always #20 clk = ~clk;

    // Adapter and slave model per port
    for (genvar k = 0; k < 3; k++) begin : g
        localparam int   MWK = (k == 2) ? 16 : 32;
        localparam int   SWK = (k == 2) ? 32 : 8;
        localparam logic ALK = (k == 0) ? BWA_ALIGN_DYNAMIC : BWA_ALIGN_NATIVE;
        localparam int   SBK = SWK / 8;
        bwa_adapter #(.MW(MWK), .SW(SWK), .ALIGN(ALK)) i_bwa_adapter (
            .clk(clk), .nrst(nrst), .mValid(mValid[k]), .mCmd(mCmd[k]),
            .mWdata(mWd[k][MWK-1:0]), .mReady(mReady[k]), .mDone(mDone[k]),
            .mRdata(mRd[k][MWK-1:0]), .sValid(sValid[k]), .sWrite(sWrite[k]),
            .sAddr(sAddr[k]), .sWdata(sWd[k][SWK-1:0]), .sByteEn(sBe[k][SBK-1:0]),
            .sAck(sAck[k]), .sRdata(sRd[k][SWK-1:0]));
        bwa_slave_model #(.SW(SWK), .SEED(k * 7)) i_bwa_slave_model (
            .clk(clk), .nrst(nrst), .sValid(sValid[k]), .sWrite(sWrite[k]),
            .sAddr(sAddr[k]), .sWdata(sWd[k][SWK-1:0]), .sByteEn(sBe[k][SBK-1:0]),
            .sAck(sAck[k]), .sRdata(sRd[k][SWK-1:0]), .nBeats(nBeats[k]));
    end

    // Compare and count
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
        end
    endtask

    // One master transfer, waits for the done pulse
    task automatic xfer(input int k, input logic wr, input logic [31:0] a,
                        input logic [31:0] d, output logic [31:0] rd);
        int t;
        @(posedge clk);
        mValid[k] <= 1'h1;
        mCmd[k]   <= '{write: wr, addr: a};
        mWd[k]    <= d;
        @(posedge clk);
        mValid[k] <= 1'h0;
        for (t = 0; t < 60; t++) begin
            @(negedge clk);
            if (mDone[k] === 1'h1) break;
        end
        chk("done", 32'h1, 32'(t < 60));
        chk("ready", 32'h0, 32'(mReady[k]));
        rd = mRd[k];
    endtask

    // Random reads and writes on one port against the shadow model
    task automatic run(input int k, input string nm);
        logic [31:0] a;
        logic [31:0] d;
        logic [31:0] rd;
        logic [31:0] ex;
        logic        wr;
        int          b0;
        for (int n = 0; n < 40; n++) begin
            wr = ($urandom % 2 == 1);
            a  = (k == 0) ? ($urandom % 15) * 4 :
                 (k == 1) ? ($urandom % 16) * 4 : ($urandom % 128) * 2;
            d  = $urandom;
            b0 = nBeats[k];
            xfer(k, wr, a, d, rd);
            if (k == 0) begin
                ex = {sh[0][a+3][7:0], sh[0][a+2][7:0], sh[0][a+1][7:0], sh[0][a][7:0]};
            end else if (k == 1) begin
                ex = {24'h0, sh[1][a/4][7:0]};
            end else begin
                ex = {16'h0, a[1] ? sh[2][a/4][31:16] : sh[2][a/4][15:0]};
            end
            if (!wr) chk({nm, " rdata"}, ex, (k == 2) ? {16'h0, rd[15:0]} : rd);
            chk({nm, " beats"}, (k == 0) ? 4 : 1, nBeats[k] - b0);
            if (wr && k == 0) begin
                for (int j = 0; j < 4; j++) sh[0][a+j] = {24'h0, d[8*j +: 8]};
            end
            if (wr && k == 1) sh[1][a/4] = {24'h0, d[7:0]};
            if (wr && k == 2) sh[2][a/4][16*a[1] +: 16] = d[15:0];
        end
        $display("test %s done", nm);
    endtask

    // Verdict and end of run
    task automatic close_out();
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // Main sequence
    initial begin
        void'($urandom(40432));
        for (int k = 0; k < 3; k++) begin
            mValid[k] = 1'h0;
            mCmd[k] = '0;
            mWd[k] = '0;
            for (int i = 0; i < 64; i++) begin
                sh[k][i] = (i * 32'h9E37_79B1 + k * 7)
                         & ((k == 2) ? 32'hFFFF_FFFF : 32'h0000_00FF);
            end
        end
        repeat (3) @(posedge clk);
        nrst <= 1'h1;
        repeat (3) @(posedge clk);
        run(0, "dynamic");
        run(1, "native");
        run(2, "wide");
        close_out();
    end

    // Hang guard, well past the expected run length
    initial begin
        #400000;
        fail_count++;
        close_out();
    end
endmodule
